// ### bdb_top.sv
/*
 * bdb_top: object-store descriptor builder with its USB 2.0 extension
 * capability. It holds the loadable fields and forces the fixed header
 * bytes. It serves the 12-byte stream to the control engine and mirrors it
 * in registers on the bus.
 * Assumes: the configuration loader and the control engine run on clock,
 * and the loader pulses its strobes once per image.
 */
`timescale 1ns/1ps
`default_nettype none
module bdb_top #(
	parameter bit SS_CAPABLE = 1'b1
) (
	input wire logic clock,
	input wire logic rst_n,
	// bus
	input wire logic hsel,
	input wire logic [bdb_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// configuration loader
	input wire logic ld_bos_stb,
	input wire logic [15:0] ld_total_len,
	input wire logic [7:0] ld_num_caps,
	input wire logic ld_ext_stb,
	input wire logic ld_ext_src,
	input wire logic [31:0] ld_ext_attr,
	input wire logic ld_flag_stb,
	input wire logic ld_flag_present,
	input wire logic ld_stored_link_pm_capable_flag,
	// descriptor byte port of the control engine
	input wire logic desc_rd,
	input wire logic [bdb_pkg::DESC_IDX_W-1:0] desc_idx,
	output logic [7:0] desc_data,
	output logic desc_valid,
	output logic lpm_mismatch
);
	typedef struct packed {
		logic [15:0] total_len;
		logic [7:0] num_caps;
		logic [31:0] attr;
		logic flag_present;
		logic flag;
		logic bos_loaded;
		logic ext_loaded;
		logic ext_refused;
		logic force_dflt;
		logic mismatch;
		logic [7:0] desc_data;
		logic desc_valid;
	} bdb_top_s;

	bdb_top_s st_ff;
	bdb_top_s nxt_st;

	logic wr_stb;
	logic [bdb_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [bdb_pkg::ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;

	logic [15:0] eff_total_len;
	logic [7:0] eff_num_caps;
	logic [31:0] base_attr;
	logic [31:0] eff_attr;
	logic eff_lpm;
	logic [8*bdb_pkg::DESC_BYTES-1:0] stream;

	bdb_ahb_slave u_slv (
		.clock(clock),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// presented fields; force_dflt lets software fall back on the defaults
	always_comb begin
		eff_total_len = st_ff.force_dflt ? bdb_pkg::DFLT_TOTAL_LEN : st_ff.total_len;
		eff_num_caps = st_ff.force_dflt ? bdb_pkg::DFLT_NUM_CAPS : st_ff.num_caps;
		base_attr = st_ff.force_dflt ? bdb_pkg::DFLT_ATTR : st_ff.attr;
		base_attr = base_attr & bdb_pkg::ATTR_KEEP_MASK;
		// the stored flag wins over the image bit, then the forcing terms
		eff_lpm = st_ff.flag_present ? st_ff.flag : base_attr[bdb_pkg::ATTR_LPM];
		eff_lpm = eff_lpm | SS_CAPABLE;
		eff_lpm = eff_lpm | base_attr[bdb_pkg::ATTR_BESL_ALT_HIRD];
		eff_attr = base_attr;
		eff_attr[bdb_pkg::ATTR_LPM] = eff_lpm;
	end

	// byte 0 sits lowest; fixed headers never come from the image
	assign stream = {eff_attr,
		bdb_pkg::EXT_CAP_TYPE, bdb_pkg::EXT_TYPE, bdb_pkg::EXT_LEN,
		eff_num_caps, eff_total_len,
		bdb_pkg::BOS_TYPE, bdb_pkg::BOS_LEN};

	// register read mux; unmapped addresses read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_addr)
			bdb_pkg::ADDR_CTRL: begin
				rd_data[bdb_pkg::CTRL_FORCE_DFLT] = st_ff.force_dflt;
			end
			bdb_pkg::ADDR_STATUS: begin
				rd_data[bdb_pkg::ST_BOS_LOADED] = st_ff.bos_loaded;
				rd_data[bdb_pkg::ST_EXT_LOADED] = st_ff.ext_loaded;
				rd_data[bdb_pkg::ST_LPM_MISMATCH] = st_ff.mismatch;
				rd_data[bdb_pkg::ST_EXT_REFUSED] = st_ff.ext_refused;
			end
			bdb_pkg::ADDR_DESC_W0: begin
				rd_data = stream[31:0];
			end
			bdb_pkg::ADDR_DESC_W1: begin
				rd_data = stream[63:32];
			end
			bdb_pkg::ADDR_DESC_W2: begin
				rd_data = stream[95:64];
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// loader, software and byte port updates
	always_comb begin
		nxt_st = st_ff;
		nxt_st.desc_valid = 1'b0;
		// the object-store fields take either nonvolatile source
		if (ld_bos_stb) begin
			nxt_st.total_len = ld_total_len;
			nxt_st.num_caps = ld_num_caps;
			nxt_st.bos_loaded = 1'b1;
		end
		// software clears the refusal flag by writing one; a new refusal wins
		if (wr_stb && wr_addr == bdb_pkg::ADDR_STATUS && wr_data[bdb_pkg::ST_EXT_REFUSED]) begin
			nxt_st.ext_refused = 1'b0;
		end
		if (wr_stb && wr_addr == bdb_pkg::ADDR_CTRL) begin
			nxt_st.force_dflt = wr_data[bdb_pkg::CTRL_FORCE_DFLT];
		end
		// an OTP image holds no attribute word, so it is refused
		if (ld_ext_stb) begin
			if (ld_ext_src == bdb_pkg::SRC_EEPROM) begin
				nxt_st.attr = ld_ext_attr;
				nxt_st.ext_loaded = 1'b1;
			end else begin
				nxt_st.ext_refused = 1'b1;
			end
		end
		if (ld_flag_stb) begin
			nxt_st.flag_present = ld_flag_present;
			nxt_st.flag = ld_stored_link_pm_capable_flag;
		end
		// mismatch shows a flag that the forced bit cannot follow
		nxt_st.mismatch = st_ff.flag_present && (st_ff.flag != eff_lpm);
		// bytes past the stream read zero
		if (desc_rd) begin
			nxt_st.desc_valid = 1'b1;
			if (desc_idx < 5'(bdb_pkg::DESC_BYTES)) begin
				nxt_st.desc_data = stream[8*desc_idx +: 8];
			end else begin
				nxt_st.desc_data = 8'h00;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{total_len: bdb_pkg::DFLT_TOTAL_LEN, num_caps: bdb_pkg::DFLT_NUM_CAPS,
				attr: bdb_pkg::DFLT_ATTR, flag_present: 1'b0, flag: 1'b0,
				bos_loaded: 1'b0, ext_loaded: 1'b0, ext_refused: 1'b0,
				force_dflt: bdb_pkg::CTRL_RESET, mismatch: 1'b0,
				desc_data: 8'h00, desc_valid: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign desc_data = st_ff.desc_data;
	assign desc_valid = st_ff.desc_valid;
	assign lpm_mismatch = st_ff.mismatch;
endmodule
`default_nettype wire

// ### bdb_pkg.sv
/*
 * bdb_pkg: constants shared by the object-store descriptor builder and its
 * bus slave. This covers register offsets, status fields, the fixed header
 * bytes and the built-in defaults.
 * Assumes: included by name before any bdb_* module is compiled.
 */
`default_nettype none
package bdb_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DESC_W0 = 8'h08;
	localparam logic [7:0] ADDR_DESC_W1 = 8'h0C;
	localparam logic [7:0] ADDR_DESC_W2 = 8'h10;
	localparam int ADDR_W = 8;

	// control register fields
	localparam int CTRL_FORCE_DFLT = 0;
	localparam logic CTRL_RESET = 1'b0;

	// status register fields
	localparam int ST_BOS_LOADED = 0;
	localparam int ST_EXT_LOADED = 1;
	localparam int ST_LPM_MISMATCH = 2;
	localparam int ST_EXT_REFUSED = 3;

	// fixed header bytes, always forced
	localparam logic [7:0] BOS_LEN = 8'h05;
	localparam logic [7:0] BOS_TYPE = 8'h0F;
	localparam logic [7:0] EXT_LEN = 8'h07;
	localparam logic [7:0] EXT_TYPE = 8'h10;
	localparam logic [7:0] EXT_CAP_TYPE = 8'h02;

	// built-in defaults of the loadable fields
	localparam logic [15:0] DFLT_TOTAL_LEN = 16'h0016;
	localparam logic [7:0] DFLT_NUM_CAPS = 8'h02;
	localparam logic [31:0] DFLT_ATTR = 32'h0000_0006;

	// attribute word layout
	localparam logic [31:0] ATTR_KEEP_MASK = 32'h0000_FF1E;
	localparam int ATTR_LPM = 1;
	localparam int ATTR_BESL_ALT_HIRD = 2;
	localparam int ATTR_BASE_VALID = 3;
	localparam int ATTR_DEEP_VALID = 4;

	// byte stream of the two descriptors served here
	localparam int DESC_BYTES = 12;
	localparam int DESC_IDX_W = 5;

	// loader source codes
	localparam logic SRC_OTP = 1'b0;
	localparam logic SRC_EEPROM = 1'b1;

	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

// ### bdb_ahb_slave.sv
/*
 * bdb_ahb_slave: AHB-Lite slave front end for the descriptor builder.
 * Writes have no wait state. Reads insert one wait state so that hrdata
 * comes from a flop.
 * Assumes: a single master, single word transfers, and the parent answering
 * rd_data combinationally from rd_addr.
 */
`timescale 1ns/1ps
`default_nettype none
module bdb_ahb_slave (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [bdb_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic wr_stb,
	output logic [bdb_pkg::ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [bdb_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data
);
	typedef struct packed {
		logic wr_pend;
		logic rd_pend;
		logic [bdb_pkg::ADDR_W-1:0] addr;
		logic ready;
		logic [31:0] rdata;
	} bdb_slv_s;

	bdb_slv_s st_ff;
	bdb_slv_s nxt_st;
	logic take;

	// every size is served as a whole word; hsize is accepted as is
	assign take = hsel && hready && (htrans == bdb_pkg::HTRANS_NONSEQ) && (hsize == 3'h2 || 1'b1);

	// address phase capture, one wait state on reads
	always_comb begin
		nxt_st = st_ff;
		nxt_st.wr_pend = 1'b0;
		if (st_ff.rd_pend) begin
			nxt_st.rd_pend = 1'b0;
			nxt_st.rdata = rd_data;
			nxt_st.ready = 1'b1;
		end
		if (take) begin
			nxt_st.addr = haddr;
			nxt_st.wr_pend = hwrite;
			nxt_st.rd_pend = !hwrite;
			nxt_st.ready = hwrite;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{wr_pend: 1'b0, rd_pend: 1'b0, addr: '0, ready: 1'b1, rdata: 32'h0000_0000};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout = st_ff.ready;
	assign hresp = bdb_pkg::HRESP_OKAY;
	assign hrdata = st_ff.rdata;
	assign wr_stb = st_ff.wr_pend; // data phase cycle; hwdata stands now
	assign wr_addr = st_ff.addr;
	assign wr_data = hwdata;
	assign rd_addr = st_ff.addr;
endmodule
`default_nettype wire

// ### bdb_top_sva.sv
/* bdb_top_sva: port checks of the descriptor builder.
 * Assumes the bdb_top ports, one clock and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module bdb_top_sva #(
	parameter bit SS_CAPABLE = 1'b1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic desc_rd,
	input wire logic [bdb_pkg::DESC_IDX_W-1:0] desc_idx,
	input wire logic [7:0] desc_data,
	input wire logic desc_valid,
	input wire logic ld_flag_stb,
	input wire logic ld_flag_present,
	input wire logic ld_stored_link_pm_capable_flag,
	input wire logic lpm_mismatch
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// a read stalls one cycle, then the data phase ends
	sequence rd_start;
		hsel && hready && htrans == 2'h2 && !hwrite;
	endsequence
	sequence rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	rd_wait_a: assert property (rd_start |=> rd_wait) else $error("read wait wrong");
	byte_valid_a: assert property (desc_rd |=> desc_valid) else $error("byte not answered");
	bos_hdr_a: assert property (desc_rd && desc_idx < 5'h02 |=> desc_data ==
		($past(desc_idx[0]) ? 8'h0F : 8'h05)) else $error("object-store header wrong");
	cap_type_a: assert property (desc_rd && desc_idx == 5'h07 |=> desc_data == 8'h02)
		else $error("capability type wrong");
	// bit2 needs bit1, a superspeed part shows bit1, bit0 reserved
	attr_low_a: assert property (desc_rd && desc_idx == 5'h08 |=> !desc_data[0] &&
		(desc_data[1] || (!SS_CAPABLE && !desc_data[2]))) else $error("attribute low bits wrong");
	attr_rsvd_a: assert property (desc_rd && desc_idx inside {5'h0A, 5'h0B} |=> desc_data == 8'h00)
		else $error("reserved attribute byte set");
	beyond_end_a: assert property (desc_rd && desc_idx >= 5'h0C |=> desc_data == 8'h00)
		else $error("byte past the end not zero");
	// lpm bit is forced on for superspeed, so a stored zero must be flagged
	lpm_flag_a: assert property (ld_flag_stb && ld_flag_present && SS_CAPABLE &&
		!ld_stored_link_pm_capable_flag |-> ##2 lpm_mismatch) else $error("mismatch not flagged");
endmodule
bind bdb_top bdb_top_sva #(.SS_CAPABLE(SS_CAPABLE)) chk_u (.clock(clock), .rst_n(rst_n),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.desc_rd(desc_rd), .desc_idx(desc_idx), .desc_data(desc_data), .desc_valid(desc_valid),
	.ld_flag_stb(ld_flag_stb), .ld_flag_present(ld_flag_present),
	.ld_stored_link_pm_capable_flag(ld_stored_link_pm_capable_flag),
	.lpm_mismatch(lpm_mismatch));
`default_nettype wire

// ### bdb_host_model.sv
/* bdb_host_model: host side reader of the descriptor byte port.
 * Assumes the builder's clock; the bench calls fetch right after an edge. */
`timescale 1ns/1ps
`default_nettype none
module bdb_host_model (
	input wire logic clock,
	input wire logic desc_valid,
	input wire logic [7:0] desc_data,
	output logic desc_rd,
	output logic [bdb_pkg::DESC_IDX_W-1:0] desc_idx,
	output logic [103:0] stream
);
	initial begin
		desc_rd = 1'b0;
		desc_idx = 5'h00;
	end
	// bytes shift in from the top, so byte 0 ends lowest
	always @(posedge clock) begin
		if (desc_valid) begin
			stream <= {desc_data, stream[103:8]};
		end
	end
	// reads one byte past the end; a released index is inverted so it never looks held
	task automatic fetch(input logic slow);
		for (int i = 0; i < 13; i++) begin
			desc_rd <= 1'b1;
			desc_idx <= 5'(i);
			@(posedge clock);
			if (slow) begin
				desc_rd <= 1'b0;
				desc_idx <= ~desc_idx;
				@(posedge clock);
			end
		end
		desc_rd <= 1'b0;
		desc_idx <= ~desc_idx;
		repeat (2) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ### tb.sv
/* tb: self-checking bench of bdb_top with the host reader model.
 * Assumes hready is the slave's own hreadyout and hsize is a word. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, ld_bos_stb = 1'b0;
	logic ld_ext_stb = 1'b0, ld_ext_src = 1'b0, ld_flag_stb = 1'b0, ld_flag_present = 1'b0;
	logic ld_flag_val = 1'b0, hreadyout, hresp, desc_rd, desc_valid, lpm_mismatch;
	logic [1:0] htrans = 2'h0;
	logic [4:0] desc_idx;
	logic [7:0] haddr = 8'h00, ld_num_caps = 8'h00, desc_data;
	logic [15:0] ld_total_len = 16'h0000;
	logic [31:0] hwdata = 32'h0, ld_ext_attr = 32'h0, hrdata, q;
	logic [103:0] stream;
	int n_mismatch = 0, samples_checked = 0;
	// rows: loaded length, count, source, attribute, attribute expected after
	logic [15:0] r_len[3] = '{16'h1234, 16'h00AB, 16'hBEEF};
	logic [7:0] r_caps[3] = '{8'h03, 8'h01, 8'h7F};
	logic r_src[3] = '{1'b1, 1'b0, 1'b1};
	logic [31:0] r_attr[3] = '{32'hFFFF_FFFF, 32'h0000_F000, 32'h0000_A504};
	logic [31:0] r_exp[3] = '{32'h0000_FF1E, 32'h0000_FF1E, 32'h0000_A506};
	always #25 clock = ~clock;
	bdb_top dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ld_bos_stb(ld_bos_stb), .ld_total_len(ld_total_len),
		.ld_num_caps(ld_num_caps), .ld_ext_stb(ld_ext_stb), .ld_ext_src(ld_ext_src),
		.ld_ext_attr(ld_ext_attr), .ld_flag_stb(ld_flag_stb), .ld_flag_present(ld_flag_present),
		.ld_stored_link_pm_capable_flag(ld_flag_val), .desc_rd(desc_rd), .desc_idx(desc_idx),
		.desc_data(desc_data), .desc_valid(desc_valid), .lpm_mismatch(lpm_mismatch));
	bdb_host_model host_u (.clock(clock), .desc_valid(desc_valid), .desc_data(desc_data),
		.desc_rd(desc_rd), .desc_idx(desc_idx), .stream(stream));
	function automatic logic [103:0] exp_s(input logic [15:0] tl, input logic [7:0] nc,
		input logic [31:0] at);
		return {8'h00, at, 24'h021007, nc, tl, 16'h0F05};
	endfunction
	task automatic chk(input string what, input logic [103:0] exp, input logic [103:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single transfer; no fixed latency assumed, hready decides
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= bdb_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= a;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
		// hsel stays up between calls; idle htrans keeps the slave quiet
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		// both loads in one cycle; the otp row must leave the attribute alone
		for (int r = 0; r < 3; r++) begin
			ld_total_len <= r_len[r];
			ld_num_caps <= r_caps[r];
			ld_ext_src <= r_src[r];
			ld_ext_attr <= r_attr[r];
			ld_bos_stb <= 1'b1;
			ld_ext_stb <= 1'b1;
			@(posedge clock);
			ld_bos_stb <= 1'b0;
			ld_ext_stb <= 1'b0;
			host_u.fetch(r[0]);
			chk("stream", exp_s(r_len[r], r_caps[r], r_exp[r]), stream);
		end
		ahb(1'b0, bdb_pkg::ADDR_DESC_W2, 32'h0);
		chk("attr word", 104'(32'h0000_A506), 104'(q));
		chk("hresp", 104'(bdb_pkg::HRESP_OKAY), 104'(hresp));
		ahb(1'b0, 8'hFC, 32'h0);
		chk("unmapped", 104'(0), 104'(q));
		// both loads seen, the otp attribute refused, no stored flag yet
		ahb(1'b0, bdb_pkg::ADDR_STATUS, 32'h0);
		chk("status", 104'(32'h0000_000B), 104'(q));
		ahb(1'b1, bdb_pkg::ADDR_STATUS, 32'h0000_0008);
		ahb(1'b0, bdb_pkg::ADDR_STATUS, 32'h0);
		chk("refusal clear", 104'(32'h0000_0003), 104'(q));
		// forcing the defaults hides the loaded fields, the headers stay fixed
		ahb(1'b1, bdb_pkg::ADDR_CTRL, 32'h0000_0001);
		ahb(1'b0, bdb_pkg::ADDR_CTRL, 32'h0);
		chk("force bit", 104'(32'h0000_0001), 104'(q));
		ahb(1'b0, bdb_pkg::ADDR_DESC_W0, 32'h0);
		chk("forced w0", 104'(32'h0016_0F05), 104'(q));
		ahb(1'b0, bdb_pkg::ADDR_DESC_W1, 32'h0);
		chk("forced w1", 104'(32'h0210_0702), 104'(q));
		ahb(1'b1, bdb_pkg::ADDR_CTRL, 32'h0);
		ahb(1'b0, bdb_pkg::ADDR_DESC_W0, 32'h0);
		chk("loaded w0", 104'(32'hBEEF_0F05), 104'(q));
		ahb(1'b0, bdb_pkg::ADDR_DESC_W1, 32'h0);
		chk("loaded w1", 104'(32'h0210_077F), 104'(q));
		// stored flag 0 disagrees with the forced lpm bit, flag 1 agrees
		for (int v = 0; v < 2; v++) begin
			ld_flag_present <= 1'b1;
			ld_flag_val <= v[0];
			ld_flag_stb <= 1'b1;
			@(posedge clock);
			ld_flag_stb <= 1'b0;
			repeat (2) @(posedge clock);
			ahb(1'b0, bdb_pkg::ADDR_STATUS, 32'h0);
			chk("mismatch", 104'({2{!v[0]}}), 104'({lpm_mismatch, q[2]}));
		end
		// a reset in mid-run must bring back the built-in defaults
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		host_u.fetch(1'b0);
		chk("reset stream", exp_s(16'h0016, 8'h02, 32'h0000_0006), stream);
		ahb(1'b0, bdb_pkg::ADDR_STATUS, 32'h0);
		chk("reset status", 104'(0), 104'(q));
		print_verdict();
	end
	initial begin
		repeat (3000) @(posedge clock);
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
